// ---- rtl/boot_strap_pkg.sv ----
/*
 Shared constants and carrier types for the reset-time pin and boot-strap block.
 Assumes a single 200 MHz system clock and synchronous, active-high reset.
*/
package boot_strap_pkg;

	// Pin functions a firmware pin setting may select
	typedef enum logic [2:0] {
		FN_HIZ,
		FN_GPIO,
		FN_ALT1,
		FN_ALT2,
		FN_ALT3,
		FN_ALT4
	} pin_fn_t;

	// Pull selection
	typedef enum logic [1:0] {
		PULL_NONE,
		PULL_UP,
		PULL_DOWN
	} pull_t;

	// Per-pin configuration written by firmware after start-up
	typedef struct packed {
		pin_fn_t fn;
		pull_t pull;
		logic gpio_out;
		logic gpio_oe;
	} pin_cfg_t;

	// Pad control driven to one pin
	typedef struct packed {
		logic out;
		logic oe;
		logic in_en;
		logic pull_up;
		logic pull_down;
	} pad_ctl_t;

	// Boot modes latched at start
	typedef enum logic [1:0] {
		BOOT_NONE,
		BOOT_NORMAL,
		BOOT_DOWNLOAD,
		BOOT_TEST
	} boot_mode_t;

	localparam int unsigned NUM_PINS = 7;
	localparam int unsigned CLK_PERIOD_PS = 5000;
	// Settle time of the pulled-up straps before sampling, in ns
	localparam int unsigned STRAP_SETTLE_NS = 1000;
	localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned CNT_W = 16;

	localparam pin_cfg_t CFG_RESET = '{fn: FN_HIZ, pull: PULL_NONE, gpio_out: 1'b0,
		gpio_oe: 1'b0};

endpackage : boot_strap_pkg

// ---- rtl/boot_strap_pin_config.sv ----
/*
 Reset-time pin states, strap sampling and host-UART pin assignment for pins 0 to 6.
 Assumes all pin inputs are synchronous to clk_sys and that firmware presents
 per-pin configuration as plain ports, applied only after a normal start.
*/
// Function
// - Low system reset holds all initial state except regulator_on
// - Regulator follows its enable strap level
// - Pin 0 high-impedance, input off around reset
// - Enabled wake pin restarts sleeping chip
// - Pins 1,2 input off, no pull
// - Pin 3 pulled up, input off in reset
// - Pin 3 low at start selects test
// - Pin 3 becomes host transmit at start
// - Download mode releases pin 3, pull-up on
// - Firmware configures pin 3 after normal start
// - Pin 4 pulled up, then host receive
// - Download mode releases pin 4, pull-up on
// - Pin 5 high at start selects download
// - Pin 5 low selects normal start
// - Pin 6 pulled up, then firmware configured
`timescale 1ns/100ps
module boot_strap_pin_config #(
	parameter int unsigned SETTLE_CYC = boot_strap_pkg::STRAP_SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic system_reset_low,
	// Straps and power
	input wire logic regulator_enable_strap,
	output logic regulator_on,
	// Pad inputs and controls, index is pin number
	input wire logic [6:0] pad_in,
	output boot_strap_pkg::pad_ctl_t pad_ctl [7],
	// Firmware configuration
	input wire boot_strap_pkg::pin_cfg_t fw_cfg [7],
	input wire logic fw_cfg_valid,
	// Sleep and wake
	input wire logic sleep_active,
	input wire logic wake_enable,
	output logic wake_request,
	// Peripheral signals
	input wire logic host_uart_tx,
	output logic host_uart_rx,
	input wire logic host_request_to_send_n,
	output logic host_clear_to_send_n,
	input wire logic aux_uart_tx,
	output logic aux_uart_rx,
	input wire logic spi_dout,
	output logic spi_din,
	input wire logic serial_periph_chip_select,
	input wire logic spi_clk,
	input wire logic pulse_out_zero,
	output logic [6:0] gpio_in,
	// Status
	output boot_strap_pkg::boot_mode_t boot_mode,
	output logic start_done
);

	// The settle counter must be able to reach a nonzero count
	if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << boot_strap_pkg::CNT_W))
	begin : g_bad_settle
		$error("SETTLE_CYC out of range");
	end

	typedef enum logic [1:0] {ST_RESET, ST_SETTLE, ST_RUN} start_st_t;

	logic rst_any;
	assign rst_any = reset || !system_reset_low;

	start_st_t st_r, st_nxt;
	logic [boot_strap_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	boot_strap_pkg::boot_mode_t mode_r, mode_nxt;
	logic cfg_ok_r, cfg_ok_nxt;
	logic wake_r, wake_nxt;
	logic [6:0] pin_in_r, pin_in_nxt;
	logic reg_on_r;

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		mode_nxt = mode_r;
		cfg_ok_nxt = cfg_ok_r;
		case (st_r)
			ST_RESET:
			begin
				st_nxt = ST_SETTLE;
				cnt_nxt = '0;
			end
			ST_SETTLE:
			begin
				if (cnt_r == SETTLE_CYC[boot_strap_pkg::CNT_W-1:0] - 1'b1)
				begin
					// Straps read once, with their pull-ups still on
					st_nxt = ST_RUN;
					if (!pad_in[3])
						mode_nxt = boot_strap_pkg::BOOT_TEST;
					else if (pad_in[5])
						mode_nxt = boot_strap_pkg::BOOT_DOWNLOAD;
					else
						mode_nxt = boot_strap_pkg::BOOT_NORMAL;
				end
				else
					cnt_nxt = cnt_r + 1'b1;
			end
			ST_RUN:
			begin
				// Firmware settings take effect only after a normal start
				if (fw_cfg_valid && mode_r == boot_strap_pkg::BOOT_NORMAL)
					cfg_ok_nxt = 1'b1;
			end
			default:
				st_nxt = ST_RESET;
		endcase
	end

	always_comb
	begin
		// Wake counts only once firmware has handed pin 0 to the wake function
		wake_nxt = sleep_active && wake_enable && pad_in[0] && cfg_ok_r &&
			fw_cfg[0].fn == boot_strap_pkg::FN_ALT1;
		pin_in_nxt = pad_in;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst_any)
		begin
			st_r <= ST_RESET;
			cnt_r <= '0;
			mode_r <= boot_strap_pkg::BOOT_NONE;
			cfg_ok_r <= 1'b0;
			wake_r <= 1'b0;
			pin_in_r <= '0;
		end
		else if (clk_en)
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			mode_r <= mode_nxt;
			cfg_ok_r <= cfg_ok_nxt;
			wake_r <= wake_nxt;
			pin_in_r <= pin_in_nxt;
		end
	end

	// Regulator follows the strap; kept registered so the output is clean
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			reg_on_r <= 1'b0;
		else if (clk_en)
			reg_on_r <= regulator_enable_strap;
	end

	assign regulator_on = reg_on_r;
	assign boot_mode = mode_r;
	assign start_done = (st_r == ST_RUN);
	assign wake_request = wake_r;

	// Pad control: fixed states before firmware owns the pin
	function automatic boot_strap_pkg::pad_ctl_t pull_of(boot_strap_pkg::pull_t p);
		pull_of = '0;
		pull_of.pull_up = (p == boot_strap_pkg::PULL_UP);
		pull_of.pull_down = (p == boot_strap_pkg::PULL_DOWN);
	endfunction : pull_of

	function automatic boot_strap_pkg::pad_ctl_t drive(logic v);
		drive = '0;
		drive.out = v;
		drive.oe = 1'b1;
	endfunction : drive

	always_comb
	begin
		boot_strap_pkg::pad_ctl_t c;
		c = '0;
		for (int i = 0; i < 7; i++)
		begin
			c = '0;
			if (st_r != ST_RUN)
			begin
				// Pins 0-2 high-impedance, 3-6 pulled up, all inputs off
				c.pull_up = (i >= 3);
			end
			else if (cfg_ok_r)
			begin
				c = pull_of(fw_cfg[i].pull);
				c.in_en = 1'b1;
				case (fw_cfg[i].fn)
					boot_strap_pkg::FN_HIZ: c.in_en = 1'b0;
					boot_strap_pkg::FN_GPIO:
					begin
						c.out = fw_cfg[i].gpio_out;
						c.oe = fw_cfg[i].gpio_oe;
					end
					boot_strap_pkg::FN_ALT1:
					begin
						if (i == 2) c = drive(pulse_out_zero);
						if (i == 3) c = drive(host_uart_tx);
						if (i == 5) c = drive(host_request_to_send_n);
					end
					boot_strap_pkg::FN_ALT2:
					begin
						if (i == 3 || i == 5) c = drive(aux_uart_tx);
					end
					boot_strap_pkg::FN_ALT3:
					begin
						if (i == 3) c = drive(spi_dout);
						if (i == 5) c = drive(serial_periph_chip_select);
						if (i == 6) c = drive(spi_clk);
					end
					boot_strap_pkg::FN_ALT4:
						if (i == 5) c = drive(host_uart_tx);
					default: c.in_en = 1'b0;
				endcase
			end
			// Test mode leaves pins 3 and 4 to the tester, with no pull of ours
			else if (mode_r == boot_strap_pkg::BOOT_DOWNLOAD && (i == 3 || i == 4))
				c.pull_up = 1'b1;
			else if (mode_r == boot_strap_pkg::BOOT_NORMAL && i == 3)
				c = drive(host_uart_tx);
			else if (mode_r == boot_strap_pkg::BOOT_NORMAL && i == 4)
				c.in_en = 1'b1;
			else if (i == 5 && mode_r != boot_strap_pkg::BOOT_NORMAL)
				c.pull_up = 1'b1;
			else if (i == 5 || i == 6)
				c.pull_up = 1'b1;
			pad_ctl[i] = c;
		end
	end

	// Inputs routed from pads to peripherals
	always_comb
	begin
		host_uart_rx = 1'b1;
		aux_uart_rx = 1'b1;
		host_clear_to_send_n = 1'b1;
		spi_din = 1'b0;
		if (mode_r == boot_strap_pkg::BOOT_NORMAL && !cfg_ok_r)
			host_uart_rx = pin_in_r[4];
		if (cfg_ok_r)
		begin
			if (fw_cfg[4].fn == boot_strap_pkg::FN_ALT1) host_uart_rx = pin_in_r[4];
			if (fw_cfg[4].fn == boot_strap_pkg::FN_ALT2) aux_uart_rx = pin_in_r[4];
			if (fw_cfg[4].fn == boot_strap_pkg::FN_ALT3) spi_din = pin_in_r[4];
			if (fw_cfg[6].fn == boot_strap_pkg::FN_ALT1) host_clear_to_send_n = pin_in_r[6];
			if (fw_cfg[6].fn == boot_strap_pkg::FN_ALT2) aux_uart_rx = pin_in_r[6];
			if (fw_cfg[6].fn == boot_strap_pkg::FN_ALT4) host_uart_rx = pin_in_r[6];
		end
		gpio_in = cfg_ok_r ? pin_in_r : '0;
	end

	AST_RESET_HOLD: assert property (@(posedge clk_sys) !system_reset_low |=>
		st_r == ST_RESET && mode_r == boot_strap_pkg::BOOT_NONE) else $error("reset not held");
	AST_REG_FOLLOW: assert property (@(posedge clk_sys) disable iff (reset)
		clk_en |=> regulator_on == $past(regulator_enable_strap)) else $error("regulator");
	AST_PIN0_HIZ: assert property (@(posedge clk_sys) disable iff (reset)
		!cfg_ok_r |-> !pad_ctl[0].oe && !pad_ctl[0].in_en) else $error("pin0 active");
	AST_PIN12_OFF: assert property (@(posedge clk_sys) disable iff (reset)
		!cfg_ok_r |-> !pad_ctl[1].in_en && !pad_ctl[2].pull_up) else $error("pin1/2 active");
	AST_PIN3_RESET: assert property (@(posedge clk_sys) disable iff (reset)
		st_r != ST_RUN |-> pad_ctl[3].pull_up && !pad_ctl[3].in_en) else $error("pin3 reset");
	AST_TEST_MODE: assert property (@(posedge clk_sys) disable iff (rst_any)
		st_r == ST_SETTLE && st_nxt == ST_RUN && !pad_in[3] && clk_en
		|=> mode_r == boot_strap_pkg::BOOT_TEST) else $error("test mode");
	AST_PIN3_TX: assert property (@(posedge clk_sys) disable iff (rst_any)
		mode_r == boot_strap_pkg::BOOT_NORMAL && !cfg_ok_r |-> pad_ctl[3].oe &&
		!pad_ctl[3].pull_up) else $error("pin3 tx");
	AST_DL_PULLS: assert property (@(posedge clk_sys) disable iff (rst_any)
		mode_r == boot_strap_pkg::BOOT_DOWNLOAD |-> pad_ctl[3].pull_up && !pad_ctl[3].oe &&
		pad_ctl[4].pull_up) else $error("download pulls");
	AST_MODE_LATCH: assert property (@(posedge clk_sys) disable iff (rst_any)
		st_r == ST_RUN |=> $stable(mode_r)) else $error("mode changed");
	// Pin states before firmware owns the pads: pins 1, 2 throughout, pin 4 after a normal start, pins 5, 6 in reset; then the normal-mode config gate and wake
	AST_PIN4_RX: assert property (@(posedge clk_sys) disable iff (rst_any)
		mode_r == boot_strap_pkg::BOOT_NORMAL && !cfg_ok_r |-> pad_ctl[4].in_en &&
		!pad_ctl[4].pull_up && !pad_ctl[4].pull_down) else $error("pin4 rx");
	AST_PIN12_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
		!cfg_ok_r |-> !pad_ctl[2].in_en && !pad_ctl[1].pull_up && !pad_ctl[1].oe &&
		!pad_ctl[2].oe) else $error("pin1/2 driven");
	AST_PIN5_RESET: assert property (@(posedge clk_sys) disable iff (reset)
		st_r != ST_RUN |-> pad_ctl[5].pull_up && !pad_ctl[5].in_en) else $error("pin5 reset");
	AST_PIN6_RESET: assert property (@(posedge clk_sys) disable iff (reset)
		st_r != ST_RUN |-> pad_ctl[6].pull_up && !pad_ctl[6].in_en) else $error("pin6 reset");
	AST_CFG_GATE: assert property (@(posedge clk_sys) disable iff (rst_any)
		mode_r != boot_strap_pkg::BOOT_NORMAL |-> !cfg_ok_r) else $error("fw cfg in wrong mode");
	AST_WAKE: assert property (@(posedge clk_sys) disable iff (rst_any)
		clk_en && sleep_active && wake_enable && pad_in[0] && cfg_ok_r &&
		fw_cfg[0].fn == boot_strap_pkg::FN_ALT1 |=> wake_request) else $error("no wake");

endmodule : boot_strap_pin_config

// ---- tb/host_strap_model.sv ----
/*
 Host-side pin model: resolves each pad level from pad controls and host drive.
 Assumes the bench changes host_drive and host_level just after a clock edge.
*/
`timescale 1ns/100ps
module host_strap_model (
	// Clock
	input wire logic clk_sys,
	// Pad side
	input wire boot_strap_pkg::pad_ctl_t pad_ctl [7],
	output logic [6:0] pad_in,
	// Host side
	input wire logic [6:0] host_drive,
	input wire logic [6:0] host_level
);
	logic flip_r;
	always_ff @(posedge clk_sys)
		flip_r <= (flip_r !== 1'b1);
	// Undriven pins with no pull, other than pin 4 which idles high, toggle so a stale level never passes for a real one
	always_comb
	begin
		for (int i = 0; i < 7; i++)
		begin
			if (pad_ctl[i].oe)
				pad_in[i] = pad_ctl[i].out;
			else if (host_drive[i])
				pad_in[i] = host_level[i];
			else if (pad_ctl[i].pull_up || i == 4)
				pad_in[i] = 1'b1;
			else if (pad_ctl[i].pull_down)
				pad_in[i] = 1'b0;
			else
				pad_in[i] = flip_r;
		end
	end
endmodule : host_strap_model

// ---- tb/boot_strap_pin_config_bench.sv ----
/*
 Self-checking bench for the reset-time pin and strap block.
 Assumes SETTLE_CYC of 4 and the host model on the pad side.
*/
`timescale 1ns/100ps
module boot_strap_pin_config_bench;
	logic clk_sys, reset, clk_en, system_reset_low, regulator_enable_strap, regulator_on;
	logic fw_cfg_valid, sleep_active, wake_enable, wake_request, start_done, b;
	logic host_uart_tx, host_uart_rx, host_request_to_send_n, host_clear_to_send_n;
	logic aux_uart_tx, aux_uart_rx, spi_dout, spi_din, serial_periph_chip_select;
	logic spi_clk, pulse_out_zero;
	logic [6:0] pad_in, gpio_in, host_drive, host_level;
	logic [31:0] seed, pseed;
	boot_strap_pkg::pad_ctl_t pad_ctl [7];
	boot_strap_pkg::pin_cfg_t fw_cfg [7];
	boot_strap_pkg::boot_mode_t boot_mode;
	int num_errors;
	int tests_run;

	boot_strap_pin_config #(.SETTLE_CYC(4)) dut_u (.clk_sys, .reset, .clk_en,
		.system_reset_low, .regulator_enable_strap, .regulator_on, .pad_in, .pad_ctl,
		.fw_cfg, .fw_cfg_valid, .sleep_active, .wake_enable, .wake_request, .host_uart_tx,
		.host_uart_rx, .host_request_to_send_n, .host_clear_to_send_n, .aux_uart_tx,
		.aux_uart_rx, .spi_dout, .spi_din, .serial_periph_chip_select, .spi_clk,
		.pulse_out_zero, .gpio_in, .boot_mode, .start_done);
	host_strap_model host_u (.clk_sys, .pad_ctl, .pad_in, .host_drive, .host_level);

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xorshift

	function automatic boot_strap_pkg::pad_ctl_t reset_pad(input int i);
		return (i < 3) ? 5'h00 : 5'h02;
	endfunction : reset_pad

	function automatic logic [1:0] exp_mode(input logic s3, input logic s5);
		return !s3 ? boot_strap_pkg::BOOT_TEST : s5 ? boot_strap_pkg::BOOT_DOWNLOAD
			: boot_strap_pkg::BOOT_NORMAL;
	endfunction : exp_mode

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_pad(input boot_strap_pkg::pad_ctl_t got, boot_strap_pkg::pad_ctl_t exp);
		chk({3'h0, got}, {3'h0, exp});
	endtask : chk_pad

	task automatic wrap_up;
		if (num_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic boot(input logic s3, input logic s5);
		reset = 1'b1;
		host_drive = s3 ? 7'h20 : 7'h28;
		host_level = {1'b0, s5, 5'h00};
		step(8);
		for (int i = 0; i < 7; i++)
			chk_pad(pad_ctl[i], reset_pad(i));
		chk({start_done, boot_mode}, 8'h00);
		reset = 1'b0;
		for (int k = 0; k < 50 && start_done !== 1'b1; k++)
			step(1);
		if (start_done !== 1'b1)
		begin
			num_errors++;
			wrap_up();
		end
		else
			chk(boot_mode, exp_mode(s3, s5));
	endtask : boot

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Peripheral outputs keep changing so pad routing is seen in earnest
	always @(posedge clk_sys)
	begin
		#1;
		pseed = xorshift(pseed);
		{host_uart_tx, host_request_to_send_n, aux_uart_tx, spi_dout,
			serial_periph_chip_select, spi_clk, pulse_out_zero} <= pseed[6:0];
	end

	initial
	begin
		#100000;
		num_errors++;
		wrap_up();
	end

	initial
	begin
		num_errors = 0;
		tests_run = 0;
		seed = 32'h0001_404F;
		pseed = 32'h0001_404F;
		{reset, system_reset_low, regulator_enable_strap, fw_cfg_valid} = 4'h4;
		clk_en = 1'b1;
		{sleep_active, wake_enable, host_drive, host_level} = 16'h0000;
		{host_uart_tx, host_request_to_send_n, aux_uart_tx, spi_dout} = 4'h0;
		{serial_periph_chip_select, spi_clk, pulse_out_zero} = 3'h0;
		for (int i = 0; i < 7; i++)
			fw_cfg[i] = boot_strap_pkg::CFG_RESET;
		boot(1'b0, 1'b1);
		boot(1'b1, 1'b1);
		fw_cfg[3] = '{boot_strap_pkg::FN_GPIO, boot_strap_pkg::PULL_DOWN, 1'b1, 1'b1};
		fw_cfg_valid = 1'b1;
		host_level[5] = 1'b0;
		step(10);
		chk({pad_ctl[3].oe, pad_ctl[3].pull_up, pad_ctl[3].pull_down}, 8'h02);
		chk({pad_ctl[4].in_en, pad_ctl[4].pull_up}, 8'h01);
		chk(boot_mode, boot_strap_pkg::BOOT_DOWNLOAD);
		fw_cfg_valid = 1'b0;
		fw_cfg[3] = boot_strap_pkg::CFG_RESET;
		boot(1'b1, 1'b0);
		for (int k = 0; k < 8; k++)
		begin
			chk({pad_ctl[3].oe, pad_ctl[3].out, pad_ctl[3].pull_up, pad_ctl[3].pull_down},
				{4'h0, 1'b1, host_uart_tx, 2'h0});
			chk({pad_ctl[4].in_en, pad_ctl[4].pull_up, pad_ctl[4].pull_down}, 8'h04);
			chk(host_uart_rx, 8'h01);
			step(1);
		end
		host_level[5] = 1'b1;
		host_drive[3] = 1'b1;
		step(10);
		chk(boot_mode, boot_strap_pkg::BOOT_NORMAL);
		host_drive[3] = 1'b0;
		for (int k = 0; k < 16; k++)
		begin
			seed = xorshift(seed);
			regulator_enable_strap = seed[3];
			step(1);
			chk(regulator_on, regulator_enable_strap);
		end
		// Clock enable low freezes the registered regulator copy
		clk_en = 1'b0;
		regulator_enable_strap = !regulator_enable_strap;
		step(2);
		chk(regulator_on, !regulator_enable_strap);
		clk_en = 1'b1;
		b = seed[7];
		fw_cfg[3] = '{boot_strap_pkg::FN_GPIO, boot_strap_pkg::PULL_DOWN, b, 1'b1};
		fw_cfg[5] = '{boot_strap_pkg::FN_GPIO, boot_strap_pkg::PULL_NONE, 1'b0, 1'b0};
		fw_cfg[0] = '{boot_strap_pkg::FN_ALT1, boot_strap_pkg::PULL_NONE, 1'b0, 1'b0};
		fw_cfg[6] = '{boot_strap_pkg::FN_ALT3, boot_strap_pkg::PULL_NONE, 1'b0, 1'b0};
		fw_cfg_valid = 1'b1;
		step(2);
		chk({pad_ctl[3].oe, pad_ctl[3].out, pad_ctl[3].pull_up, pad_ctl[3].pull_down},
			{4'h0, 1'b1, b, 2'h1});
		chk(pad_ctl[5].pull_up, 8'h00);
		chk({pad_ctl[6].oe, pad_ctl[6].out}, {6'h00, 1'b1, spi_clk});
		{host_drive[0], host_level[0], sleep_active, wake_enable} = 4'hF;
		for (int k = 0; k < 6 && wake_request !== 1'b1; k++)
			step(1);
		chk(wake_request, 8'h01);
		chk(gpio_in[0], 8'h01);
		wake_enable = 1'b0;
		step(4);
		chk(wake_request, 8'h00);
		system_reset_low = 1'b0;
		step(1);
		chk({start_done, boot_mode}, 8'h00);
		chk_pad(pad_ctl[3], reset_pad(3));
		system_reset_low = 1'b1;
		wrap_up();
	end
endmodule : boot_strap_pin_config_bench
